/* verilog/pmcap_pkg.sv */
// Purpose: Constants for the power management capability register bank
// Assumes: Config space reached as aligned dwords with byte enables
// Notes: Test alias lives in the separate BCR index space
package pmcap_pkg;
	// Config space dword addresses (capability word sits in upper half of 0x40)
	localparam logic [7:0] PMCAP_CAP_DW_ADDR = 8'h40;
	localparam logic [7:0] PMCAP_CSR_DW_ADDR = 8'h44;
	localparam logic [7:0] PMCAP_CAP_OFFSET = 8'h42;
	localparam logic [7:0] PMCAP_CSR_OFFSET = 8'h44;
	localparam logic [7:0] PMCAP_ALIAS_INDEX = 8'h24;
	// Capability word fields
	localparam int PMCAP_WAKE_SUP_LSB = 11;
	localparam int PMCAP_WAKE_SUP_MSB = 15;
	localparam int PMCAP_D3COLD_BIT = 15;
	localparam int PMCAP_D2_BIT = 10;
	localparam int PMCAP_D1_BIT = 9;
	localparam int PMCAP_RES_LSB = 6;
	localparam int PMCAP_RES_MSB = 8;
	localparam int PMCAP_DSI_BIT = 5;
	localparam int PMCAP_AUX_BIT = 4;
	localparam int PMCAP_CLK_BIT = 3;
	localparam int PMCAP_VER_MSB = 2;
	localparam logic [2:0] PMCAP_VERSION = 3'h1;
	// Control/status word fields
	localparam int PMCAP_FLAG_BIT = 15;
	localparam int PMCAP_SCALE_LSB = 13;
	localparam int PMCAP_SCALE_MSB = 14;
	localparam int PMCAP_SEL_LSB = 9;
	localparam int PMCAP_SEL_MSB = 12;
	localparam int PMCAP_WEN_BIT = 8;
	localparam int PMCAP_PST_MSB = 1;
	// Byte lanes of the control/status word
	localparam int PMCAP_LANE_HI = 1;
	localparam int PMCAP_LANE_LO = 0;
	localparam int PMCAP_HALF = 16;
	localparam int PMCAP_SEL_N = 16;
	localparam logic [15:0] PMCAP_CAP_RESET = 16'h0001;
	localparam logic [1:0] PMCAP_PST_D0 = 2'h0;
endpackage

/* verilog/pmcap_regs.sv */
// Purpose: Power management capability and control/status registers
// Assumes: rst_in is power-on reset; h_reset_in, s_reset_in, stop_in are lesser resets
// Notes: Reads answer one cycle after the strobe with a registered ack
// Summary of operation
// - Capability word loads from serial memory; readable via test alias
// - Top five capability bits flag per-state wake capability, read only
// - Wake field bit 11 is D0, upward to bit 15 for D3cold
// - D2 support flag reads 1 exactly when D2 supported
// - D1 support flag reads 1 exactly when D1 supported
// - Host writes zeros to reserved bits 8-6; device reads them as zero
// - Device-specific initialization flag reads 1 when extra setup is needed
// - Aux power flag reads 0 unless D3cold wake is supported
// - Bus clock flag reads 0 when no wake state is supported
// - Low three capability bits always read version code 001b
// - Wake event flag sets whenever wake would assert, enable ignored
// - Writing 1 clears wake event flag and stops wake; 0 leaves it
// - Wake event flag cleared only by a write of one or power-on reset; lesser resets leave it
// - Read-only scale field reports data scaling for current selection
// - Four-bit data select is read/write, sticky, power-on reset only
// - Wake enable gates wake pin assertion; sticky, power-on reset only
// - Power state field read/write but has no effect on operation
`timescale 1ns/1ps
module pmcap_regs
	import pmcap_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic h_reset_in,
	input wire logic s_reset_in,
	input wire logic stop_in,
	input wire logic ee_load_in,
	input wire logic [15:0] ee_cap_in,
	input wire logic [31:0] ee_scale_in,
	input wire logic wake_event_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic cfg_rd_in,
	input wire logic cfg_wr_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_ack_out,
	input wire logic [7:0] bcr_index_in,
	input wire logic bcr_rd_in,
	input wire logic bcr_wr_in,
	input wire logic [15:0] bcr_wdata_in,
	output logic [15:0] bcr_rdata_out,
	output logic bcr_ack_out,
	output logic wake_pin_out,
	output logic wake_pin_oe_n_out
);

	logic [15:0] cap_q;
	logic [15:0] cap_d;
	logic [1:0] scale_mem_q [PMCAP_SEL_N];
	logic flag_q;
	logic flag_d;
	logic wen_q;
	logic [3:0] sel_q;
	logic [1:0] pst_q;
	logic [31:0] cfg_rdata_q;
	logic [31:0] cfg_rdata_d;
	logic cfg_ack_q;
	logic [15:0] bcr_rdata_q;
	logic [15:0] bcr_rdata_d;
	logic bcr_ack_q;
	logic wake_drive_q;

	// Shape a raw capability word into what software may see
	function automatic logic [15:0] cap_view(input logic [15:0] raw);
		logic [15:0] v;
		v = raw;
		v[PMCAP_RES_MSB:PMCAP_RES_LSB] = '0;
		v[PMCAP_AUX_BIT] = raw[PMCAP_AUX_BIT] & raw[PMCAP_D3COLD_BIT];
		v[PMCAP_CLK_BIT] = raw[PMCAP_CLK_BIT] & (|raw[PMCAP_WAKE_SUP_MSB:PMCAP_WAKE_SUP_LSB]);
		v[PMCAP_VER_MSB:0] = PMCAP_VERSION;
		return v;
	endfunction

	wire logic [15:0] cap_vis = cap_view(cap_q);
	wire logic cfg_hit_cap = (cfg_addr_in == PMCAP_CAP_DW_ADDR);
	wire logic cfg_hit_csr = (cfg_addr_in == PMCAP_CSR_DW_ADDR);
	wire logic bcr_hit = (bcr_index_in == PMCAP_ALIAS_INDEX);
	wire logic csr_wr = cfg_wr_in & cfg_hit_csr;
	wire logic wr_hi = csr_wr & cfg_be_in[PMCAP_LANE_HI];
	wire logic wr_lo = csr_wr & cfg_be_in[PMCAP_LANE_LO];
	wire logic [1:0] scale_cur = scale_mem_q[sel_q];
	wire logic [15:0] csr_vis = {flag_q, scale_cur, sel_q, wen_q, 6'h00, pst_q};
	wire logic clear_req = wr_hi & cfg_wdata_in[PMCAP_FLAG_BIT];

	// Serial memory load wins over a test write
	assign cap_d = ee_load_in ? ee_cap_in :
		((bcr_wr_in & bcr_hit) ? bcr_wdata_in : cap_q);
	// Set beats a write-one clear in the same cycle
	assign flag_d = wake_event_in | (flag_q & ~clear_req);
	assign cfg_rdata_d = cfg_hit_cap ? {cap_vis, PMCAP_HALF'(0)} :
		(cfg_hit_csr ? {PMCAP_HALF'(0), csr_vis} : 32'h0000_0000);
	// Test alias returns the same word
	assign bcr_rdata_d = bcr_hit ? cap_vis : 16'h0000;

	// Sticky state only sees power-on reset
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cap_q <= PMCAP_CAP_RESET;
			flag_q <= 1'b0;
			wen_q <= 1'b0;
			sel_q <= 4'h0;
		end else begin
			cap_q <= cap_d;
			flag_q <= flag_d;
			if (wr_hi) begin
				wen_q <= cfg_wdata_in[PMCAP_WEN_BIT];
			end
			if (wr_hi) begin
				sel_q <= cfg_wdata_in[PMCAP_SEL_MSB:PMCAP_SEL_LSB];
			end
		end
	end

	// Scale table only changes on a serial memory load
	genvar gi;
	generate
		for (gi = 0; gi < PMCAP_SEL_N; gi++) begin : g_scale
			always_ff @(posedge ref_clk_in) begin
				if (rst_in) begin
					scale_mem_q[gi] <= 2'h0;
				end else if (ee_load_in) begin
					scale_mem_q[gi] <= ee_scale_in[2*gi +: 2];
				end
			end
		end
	endgenerate

	// Power state is storage only; hardware reset returns it to D0
	always_ff @(posedge ref_clk_in) begin
		if (rst_in | h_reset_in) begin
			pst_q <= PMCAP_PST_D0;
		end else if (wr_lo) begin
			pst_q <= cfg_wdata_in[PMCAP_PST_MSB:0];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cfg_rdata_q <= 32'h0000_0000;
			cfg_ack_q <= 1'b0;
			bcr_rdata_q <= 16'h0000;
			bcr_ack_q <= 1'b0;
			wake_drive_q <= 1'b0;
		end else begin
			if (cfg_rd_in) begin
				cfg_rdata_q <= cfg_rdata_d;
			end
			cfg_ack_q <= cfg_rd_in | cfg_wr_in;
			if (bcr_rd_in) begin
				bcr_rdata_q <= bcr_rdata_d;
			end
			bcr_ack_q <= bcr_rd_in | bcr_wr_in;
			wake_drive_q <= flag_d & wen_q & ~(wr_hi & ~cfg_wdata_in[PMCAP_WEN_BIT]);
		end
	end

	assign cfg_rdata_out = cfg_rdata_q;
	assign cfg_ack_out = cfg_ack_q;
	assign bcr_rdata_out = bcr_rdata_q;
	assign bcr_ack_out = bcr_ack_q;
	// Open-drain: pin value always low, only the enable moves
	assign wake_pin_out = 1'b0;
	assign wake_pin_oe_n_out = ~wake_drive_q;

	// This combined lesser reset exists only to prove they leave sticky bits alone
	wire logic lesser_reset = h_reset_in | s_reset_in | stop_in;

	a_flag_sticky_lesser: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(lesser_reset & flag_q & ~clear_req) |=> flag_q)
		else $error("wake flag lost on lesser reset");
	a_flag_set_event: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		wake_event_in |=> flag_q)
		else $error("wake flag not set by event");
	a_flag_clear_one: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(clear_req & ~wake_event_in) |=> (~flag_q & wake_pin_oe_n_out))
		else $error("wake flag or pin not cleared");
	a_flag_write_zero: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(flag_q & ~clear_req) |=> flag_q)
		else $error("wake flag changed without write one");
	a_pin_needs_enable: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		~wen_q |=> wake_pin_oe_n_out)
		else $error("wake pin driven while disabled");
	a_cap_version_read: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap) |=>
			(cfg_ack_out & cfg_rdata_out[PMCAP_HALF+PMCAP_VER_MSB:PMCAP_HALF] == PMCAP_VERSION))
		else $error("version code wrong");
	a_cap_aux_gate: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(bcr_rd_in & bcr_hit & ~cap_q[PMCAP_D3COLD_BIT]) |=> ~bcr_rdata_out[PMCAP_AUX_BIT])
		else $error("aux flag set without D3cold wake");
	a_cap_clk_gate: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(bcr_rd_in & bcr_hit & ~(|cap_q[PMCAP_WAKE_SUP_MSB:PMCAP_WAKE_SUP_LSB]))
			|=> ~bcr_rdata_out[PMCAP_CLK_BIT])
		else $error("clock flag set without wake support");
	a_cap_alias_match: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(ee_load_in & ~bcr_wr_in) ##1 (bcr_rd_in & bcr_hit & ~ee_load_in & ~bcr_wr_in)
			|=> bcr_rdata_out[15:PMCAP_D1_BIT] == $past(ee_cap_in[15:PMCAP_D1_BIT], 2))
		else $error("alias does not show loaded word");
	a_sel_sticky: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		~wr_hi |=> $stable(sel_q))
		else $error("data select changed without write");

	// Capability word source and alias
	a_cap_load_all: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		ee_load_in |=> cap_q == $past(ee_cap_in))
		else $error("capability word not loaded");
	a_cap_hold_idle: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(~ee_load_in & ~(bcr_wr_in & bcr_hit)) |=> $stable(cap_q))
		else $error("capability word changed without load");
	a_alias_ack_seen: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(bcr_rd_in | bcr_wr_in) |=> bcr_ack_out)
		else $error("alias access not acknowledged");
	a_alias_other_zero: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(bcr_rd_in & ~bcr_hit) |=> bcr_rdata_out == 16'h0000)
		else $error("unmapped alias index read nonzero");
	a_alias_version_read: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(bcr_rd_in & bcr_hit) |=> bcr_rdata_out[PMCAP_VER_MSB:0] == PMCAP_VERSION)
		else $error("alias version code wrong");
	a_alias_res_zero: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(bcr_rd_in & bcr_hit) |=> bcr_rdata_out[PMCAP_RES_MSB:PMCAP_RES_LSB] == 3'h0)
		else $error("alias reserved bits nonzero");

	// Capability fields as read over config space
	a_wake_field_ro: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap) |=> cfg_rdata_out[31:27] == $past(cap_q[15:11]))
		else $error("wake state field wrong");
	a_wake_top_d3cold: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap)
			|=> cfg_rdata_out[PMCAP_HALF+PMCAP_D3COLD_BIT] == $past(cap_q[PMCAP_D3COLD_BIT]))
		else $error("D3cold wake bit misplaced");
	a_wake_low_d0: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap)
			|=> cfg_rdata_out[PMCAP_HALF+PMCAP_WAKE_SUP_LSB] == $past(cap_q[PMCAP_WAKE_SUP_LSB]))
		else $error("D0 wake bit misplaced");
	a_d2_flag_read: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap) |=> cfg_rdata_out[PMCAP_HALF+PMCAP_D2_BIT] == $past(cap_q[PMCAP_D2_BIT]))
		else $error("D2 support flag wrong");
	a_d1_flag_read: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap) |=> cfg_rdata_out[PMCAP_HALF+PMCAP_D1_BIT] == $past(cap_q[PMCAP_D1_BIT]))
		else $error("D1 support flag wrong");
	a_res_read_zero: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap) |=> cfg_rdata_out[24:22] == 3'h0)
		else $error("reserved capability bits nonzero");
	a_dsi_flag_read: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap)
			|=> cfg_rdata_out[PMCAP_HALF+PMCAP_DSI_BIT] == $past(cap_q[PMCAP_DSI_BIT]))
		else $error("init flag wrong");
	a_aux_cfg_gate: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap & ~cap_q[PMCAP_D3COLD_BIT])
			|=> ~cfg_rdata_out[PMCAP_HALF+PMCAP_AUX_BIT])
		else $error("aux flag read without D3cold wake");
	a_clk_cfg_gate: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap & ~(|cap_q[PMCAP_WAKE_SUP_MSB:PMCAP_WAKE_SUP_LSB]))
			|=> ~cfg_rdata_out[PMCAP_HALF+PMCAP_CLK_BIT])
		else $error("clock flag read without wake support");
	a_cap_low_zero: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_cap) |=> cfg_rdata_out[15:0] == 16'h0000)
		else $error("capability dword low half nonzero");

	// Wake flag, enable and pin
	a_flag_set_disabled: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(wake_event_in & ~wen_q) |=> flag_q)
		else $error("wake flag not set while disabled");
	a_flag_event_clear: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(wake_event_in & clear_req) |=> flag_q)
		else $error("clear beat a wake event");
	a_pin_asserts: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(wake_event_in & wen_q & ~wr_hi) |=> ~wake_pin_oe_n_out)
		else $error("wake pin not driven while enabled");
	a_pin_release_clear: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(clear_req & ~wake_event_in) |=> wake_pin_oe_n_out)
		else $error("wake pin held after clear");
	a_wen_sticky: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		~wr_hi |=> $stable(wen_q))
		else $error("wake enable changed without write");
	a_wen_write: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		wr_hi |=> wen_q == $past(cfg_wdata_in[PMCAP_WEN_BIT]))
		else $error("wake enable write lost");
	a_sel_write: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		wr_hi |=> sel_q == $past(cfg_wdata_in[PMCAP_SEL_MSB:PMCAP_SEL_LSB]))
		else $error("data select write lost");

	// Scale, power state and bus answer
	a_scale_read: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in & cfg_hit_csr)
			|=> cfg_rdata_out[PMCAP_SCALE_MSB:PMCAP_SCALE_LSB] == $past(scale_cur))
		else $error("scale field wrong");
	a_scale_sticky: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(~ee_load_in & ~wr_hi) |=> $stable(scale_cur))
		else $error("scale changed without load or select");
	a_pst_write: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(wr_lo & ~h_reset_in) |=> pst_q == $past(cfg_wdata_in[PMCAP_PST_MSB:0]))
		else $error("power state write lost");
	a_pst_no_effect: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(wr_lo & ~wr_hi & ~wake_event_in) |=> flag_q == $past(flag_q))
		else $error("power state write moved wake flag");
	a_csr_ack_seen: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(cfg_rd_in | cfg_wr_in) |=> cfg_ack_out)
		else $error("config access not acknowledged");
	a_ack_one_cycle: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(~cfg_rd_in & ~cfg_wr_in) |=> ~cfg_ack_out)
		else $error("config ack without request");
endmodule

/* dv/pmcap_wake_line.sv */
// Purpose: Open-drain wake line as seen by the system
// Assumes: oe_n low means the pin pulls the line
// Notes: The system pull-up holds the line high when released
`timescale 1ns/1ps
module pmcap_wake_line (
	input wire logic pin_in,
	input wire logic oe_n_in,
	output logic line_out
);
	// Released line must not echo the pin value
	assign line_out = oe_n_in ? 1'b1 : pin_in;
endmodule

/* dv/tb.sv */
// Purpose: Self-checking bench for pmcap_regs
// Assumes: Pulse strobes, ack one cycle after each request
// Notes: Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module tb
	import pmcap_pkg::*;
;
	logic clk, rst, hr, sr, st, ld, ev, crd, cwr, brd, bwr, cak, bak, wp, woe, wl;
	logic [15:0] cap, bwd, brq;
	logic [31:0] scl, cwd, crq, q;
	logic [7:0] ca, bi;
	logic [3:0] be;
	int n_mismatch, n_compared;
	logic [15:0] raw [3] = '{16'hFFFF, 16'h07FF, 16'h7818};
	logic [15:0] shp [3] = '{16'hFE39, 16'h0621, 16'h7809};
	pmcap_regs i_dut (.ref_clk_in(clk), .rst_in(rst), .h_reset_in(hr), .s_reset_in(sr),
		.stop_in(st), .ee_load_in(ld), .ee_cap_in(cap), .ee_scale_in(scl),
		.wake_event_in(ev), .cfg_addr_in(ca), .cfg_be_in(be), .cfg_rd_in(crd),
		.cfg_wr_in(cwr), .cfg_wdata_in(cwd), .cfg_rdata_out(crq), .cfg_ack_out(cak),
		.bcr_index_in(bi), .bcr_rd_in(brd), .bcr_wr_in(bwr), .bcr_wdata_in(bwd),
		.bcr_rdata_out(brq), .bcr_ack_out(bak), .wake_pin_out(wp), .wake_pin_oe_n_out(woe));
	pmcap_wake_line i_line (.pin_in(wp), .oe_n_in(woe), .line_out(wl));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
		ca = a;
		be = 4'h3;
		cwd = d;
		crd = !wr;
		cwr = wr;
		step(1);
		crd = 0;
		cwr = 0;
		for (int k = 0; k < 4 && cak !== 1'b1; k++) step(1);
		check(32'(cak), 32'h1);
		q = crq;
		step(1);
	endtask
	task automatic bcr(input logic wr, input logic [7:0] i, input logic [15:0] d);
		bi = i;
		bwd = d;
		brd = !wr;
		bwr = wr;
		step(1);
		brd = 0;
		bwr = 0;
		for (int k = 0; k < 4 && bak !== 1'b1; k++) step(1);
		check(32'(bak), 32'h1);
		q = {16'h0000, brq};
		step(1);
	endtask
	task automatic load(input logic [15:0] c);
		cap = c;
		ld = 1;
		step(1);
		ld = 0;
	endtask
	task automatic pulse_wake;
		ev = 1;
		step(1);
		ev = 0;
		step(1);
	endtask
	task automatic summarize;
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{hr, sr, st, ld, ev, crd, cwr, brd, bwr} = '0;
		rst = 1;
		{cap, bwd, scl, cwd, ca, bi, be} = '0;
		n_mismatch = 0;
		n_compared = 0;
		step(20);
		rst = 0;
		cfg(0, PMCAP_CAP_DW_ADDR, 32'h0); check(q, 32'h00010000);
		cfg(0, PMCAP_CSR_DW_ADDR, 32'h0); check(q, 32'h00000000);
		cfg(0, 8'h48, 32'h0); check(q, 32'h00000000);
		// Scale entry 5 carries code 3
		scl = 32'h00000C00;
		for (int i = 0; i < 3; i++) begin
			load(raw[i]);
			bcr(0, PMCAP_ALIAS_INDEX, 16'h0); check(q, {16'h0000, shp[i]});
			cfg(0, PMCAP_CAP_DW_ADDR, 32'h0); check(q, {shp[i], 16'h0000});
		end
		bcr(1, PMCAP_ALIAS_INDEX, 16'h8000);
		bcr(0, PMCAP_ALIAS_INDEX, 16'h0); check(q, 32'h00008001);
		bcr(0, 8'h25, 16'h0); check(q, 32'h00000000);
		cfg(1, PMCAP_CAP_DW_ADDR, 32'hFFFF0000);
		cfg(0, PMCAP_CAP_DW_ADDR, 32'h0); check(q, 32'h80010000);
		cfg(1, PMCAP_CSR_DW_ADDR, 32'h0B03);
		cfg(0, PMCAP_CSR_DW_ADDR, 32'h0); check(q, 32'h00006B03);
		pulse_wake;
		check(32'(wl), 32'h0);
		cfg(0, PMCAP_CSR_DW_ADDR, 32'h0); check(q, 32'h0000EB03);
		cfg(1, PMCAP_CSR_DW_ADDR, 32'h0B00);
		cfg(0, PMCAP_CSR_DW_ADDR, 32'h0); check(q, 32'h0000EB00);
		{hr, sr, st} = 3'h7;
		step(1);
		{hr, sr, st} = 3'h0;
		step(1);
		cfg(0, PMCAP_CSR_DW_ADDR, 32'h0); check(q, 32'h0000EB00);
		check(32'(wl), 32'h0);
		// host clears the flag by writing one to bit 15
		cfg(1, PMCAP_CSR_DW_ADDR, 32'h8B00); check(32'(wl), 32'h1);
		cfg(0, PMCAP_CSR_DW_ADDR, 32'h0); check(q, 32'h00006B00);
		cfg(1, PMCAP_CSR_DW_ADDR, 32'h0A00);
		pulse_wake;
		check(32'(wl), 32'h1);
		cfg(0, PMCAP_CSR_DW_ADDR, 32'h0); check(q, 32'h0000EA00);
		rst = 1;
		step(2);
		rst = 0;
		cfg(0, PMCAP_CSR_DW_ADDR, 32'h0); check(q, 32'h00000000);
		summarize;
	end
	// Tests need under a hundred cycles; allow ten thousand
	initial begin
		#200000;
		n_mismatch++;
		summarize;
	end
endmodule
